// ==== flash_engine_pkg.sv ====
// Operation
// (R1) 52h, 3 address bytes: erase 32 KB block.
// (R2) d8h, 3 address bytes: erase 64 KB block.
// (R3) protected block: erase dropped.
// (R4) host sends write enable before each write.
// (R5) work starts after chip select rises.
// (R6) c7h or 60h erases the chip.
// (R7) no chip erase while protected.
// (R8) 02h, 3 address, 1 to 256 bytes: program.
// (R9) partial last byte dropped.
// (R10) only last 256 bytes kept.
// (R11) page wraps, never carries.
// (R12) 32h: address and data on four lines.
// (R13) host sets quad config bit for 32h.
// (R14) second suspend ignored.
// (R15) no suspend in chip erase, nor chip erase in suspend.
// (R16) host spaces suspends 500 us apart.
// (R17) b0h sets erase or program suspended flag.
// (R18) no program into suspended erase block.
// (R19) no erase over suspended program page.
// (R20) 30h resumes, clears flag, not while busy.
// (R21) 88h, 2 address, dummies, security id out.
// (R22) a5h programs security id user range.
// (R23) 85h locks security id, busy op.
// (R24) 06h sets write enable latch.
// (R25) 05h status readable any time.
// (R26) busy high during each operation.
// (R27) needs complete opcode and address; a partial opcode repeats the last whole one when that needs no address.
package flash_engine_pkg;
  localparam logic [7:0] op_wr_en    = 8'h06;
  localparam logic [7:0] op_status   = 8'h05;
  localparam logic [7:0] op_erase32  = 8'h52;
  localparam logic [7:0] op_erase64  = 8'hd8;
  localparam logic [7:0] op_chip_a   = 8'hc7;
  localparam logic [7:0] op_chip_b   = 8'h60;
  localparam logic [7:0] op_prog     = 8'h02;
  localparam logic [7:0] op_qprog    = 8'h32;
  localparam logic [7:0] op_suspend  = 8'hb0;
  localparam logic [7:0] op_resume   = 8'h30;
  localparam logic [7:0] op_sid_read = 8'h88;
  localparam logic [7:0] op_sid_prog = 8'ha5;
  localparam logic [7:0] op_sid_lock = 8'h85;

  localparam int unsigned clk_ns                      = 10;
  localparam int unsigned erase_time_us               = 25000;
  localparam int unsigned chip_erase_time_us          = 50000;
  localparam int unsigned prog_time_us                = 1500;
  localparam int unsigned security_id_program_time_us = 1500;
  localparam int unsigned suspend_time_us             = 10;
  localparam int unsigned erase_cyc = erase_time_us * 1000 / clk_ns;
  localparam int unsigned chip_cyc  = chip_erase_time_us * 1000 / clk_ns;
  localparam int unsigned prog_cyc  = prog_time_us * 1000 / clk_ns;
  localparam int unsigned sid_cyc   =
    security_id_program_time_us * 1000 / clk_ns;
  localparam logic [23:0] susp_cyc  =
    24'(suspend_time_us * 1000 / clk_ns);

  localparam logic [15:0] hdr_addr    = 16'h0004;
  localparam logic [15:0] hdr_sid     = 16'h0003;
  localparam logic [15:0] hdr_st_spi  = 16'h0001;
  localparam logic [15:0] hdr_st_quad = 16'h0002;
  localparam logic [15:0] hdr_sr_spi  = 16'h0004;
  localparam logic [15:0] hdr_sr_quad = 16'h0006;
  localparam logic [15:0] sid_user_lo = 16'h0010;
  localparam logic [15:0] sid_user_hi = 16'h07ff;
  localparam logic [8:0]  page_bytes  = 9'h100;
  localparam logic [3:0]  lane_spi    = 4'h2;
  localparam logic [3:0]  lane_quad   = 4'hf;
  localparam logic [2:0]  pin_rst     = 3'h1;

  typedef enum logic [2:0] {
    kind_none, kind_erase32, kind_erase64, kind_chip,
    kind_prog, kind_sid_prog, kind_sid_lock
  } op_kind_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_run  = 3'b010,
    st_susp = 3'b100
  } engine_state_t;

  typedef struct packed {
    op_kind_t    kind;
    logic [23:0] addr;
    logic [8:0]  count;
  } mem_req_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } sio_drive_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       wel;
    logic       busy;
  } status_t;
endpackage

// ==== flash_erase_program_suspend_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program_suspend_engine #(
  parameter int unsigned erase_cycles = flash_engine_pkg::erase_cyc,
  parameter int unsigned chip_cycles  = flash_engine_pkg::chip_cyc,
  parameter int unsigned prog_cycles  = flash_engine_pkg::prog_cyc,
  parameter int unsigned sid_cycles   = flash_engine_pkg::sid_cyc
) (
  input  wire logic                         ref_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         link_sck,
  input  wire logic                         ce_n,
  input  wire logic [3:0]                   sio_in,
  output var  flash_engine_pkg::sio_drive_t sio,
  input  wire logic                         quad_io_protocol,
  input  wire logic                         quad_io_config_bit,
  input  wire logic [15:0]                  protect_mask,
  output logic      [10:0]                  sid_rd_addr,
  input  wire logic [7:0]                   sid_rd_data,
  output var  flash_engine_pkg::mem_req_t   mem_req,
  output logic                              mem_req_valid,
  output logic                              mem_done,
  input  wire logic [7:0]                   page_rd_idx,
  output logic      [7:0]                   page_rd_data,
  output logic                              busy,
  output logic                              write_enable_latch,
  output logic                              erase_suspended_flag,
  output logic                              program_suspended_flag,
  output logic                              sid_locked
);
  import flash_engine_pkg::*;

  // ----------------------------------------
  // shared decoding
  // ----------------------------------------
  function automatic logic is_read(input logic [7:0] op);
    return op == op_status || op == op_sid_read;
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    return op == op_prog || op == op_qprog || op == op_sid_prog;
  endfunction

  function automatic logic [15:0] hdr_len(input logic [7:0] op,
                                          input logic       q);
    if (op == op_status)
      return q ? hdr_st_quad : hdr_st_spi;
    if (op == op_sid_read)
      return q ? hdr_sr_quad : hdr_sr_spi;
    if (op == op_sid_prog)
      return hdr_sid;
    return hdr_addr;
  endfunction

  // same erase block; only bits up to the top address bit count
  function automatic logic in_block(input logic [23:0] a,
                                    input logic [23:0] b,
                                    input logic        w64);
    return w64 ? a[18:16] == b[18:16] : a[18:15] == b[18:15];
  endfunction

  function automatic logic prot_hit(input logic [15:0] m,
                                    input logic [23:0] a,
                                    input logic        w64);
    logic [3:0] i;
    i = a[18:15];
    return w64 ? (m[{i[3:1], 1'b0}] | m[{i[3:1], 1'b1}]) : m[i];
  endfunction

  // ----------------------------------------
  // link side
  // ----------------------------------------
  logic        frame_clr, frame_seq, wide, byte_done, data_we, tx_go, fetch;
  logic        busy_l1, busy_l2, wel_l1, wel_l2, quad_l1, quad_l2;
  logic        quad_core, quad_cfg;
  logic [2:0]  bit_cnt;
  logic [3:0]  tx_left;
  logic [8:0]  data_cnt;
  logic [15:0] byte_idx, next_idx, frame_bytes;
  logic [23:0] addr;
  logic [7:0]  rx_sh, opcode, wr_ptr, tx_sh, new_byte, cur_op, byte_out;
  logic [7:0]  page_buf [256];
  status_t     status_l;

  // chip select high ends the frame even with the clock stopped
  assign frame_clr = ce_n | sys_rst;
  assign wide      = quad_l2 | (byte_idx != 16'h0 && opcode == op_qprog); // R12
  assign new_byte  = wide ? {rx_sh[3:0], sio_in} : {rx_sh[6:0], sio_in[0]};
  assign byte_done = bit_cnt == (wide ? 3'h4 : 3'h7);
  assign cur_op    = (byte_idx == 16'h0) ? new_byte : opcode;
  assign next_idx  = byte_idx + {15'h0, byte_done};
  assign data_we   = byte_done && is_prog(cur_op) &&
                     byte_idx >= hdr_len(cur_op, quad_l2);
  assign tx_go     = is_read(cur_op) &&
                     next_idx >= hdr_len(cur_op, quad_l2); // R21 R25
  assign fetch     = tx_left == 4'h0;
  assign status_l  = '{rsvd: 6'h0, wel: wel_l2, busy: busy_l2};
  assign byte_out  = !fetch ? tx_sh :
                     (cur_op == op_status) ? status_l : sid_rd_data;

  // a partial byte never reaches byte_done
  always_ff @(posedge link_sck or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt  <= 3'h0;
      byte_idx <= 16'h0;
      tx_left  <= 4'h0;
      sio      <= '0;
    end else begin
      bit_cnt <= byte_done ? 3'h0 : bit_cnt + (wide ? 3'h4 : 3'h1); // R9
      if (byte_done && byte_idx != 16'hffff) byte_idx <= next_idx;
      if (tx_go) begin
        tx_left  <= (fetch ? 4'h8 : tx_left) - (quad_l2 ? 4'h4 : 4'h1);
        sio.oe   <= quad_l2 ? lane_quad : lane_spi;
        sio.dout <= quad_l2 ? byte_out[7:4] : {2'h0, byte_out[7], 1'h0};
      end
    end
  end

  // kept past frame end for the core
  always_ff @(posedge link_sck or posedge sys_rst) begin
    if (sys_rst) begin
      frame_seq   <= 1'b0;
      frame_bytes <= 16'h0;
      data_cnt    <= 9'h0;
      opcode      <= 8'h0;
      addr        <= 24'h0;
      wr_ptr      <= 8'h0;
      rx_sh       <= 8'h0;
      tx_sh       <= 8'h0;
      sid_rd_addr <= 11'h0;
    end else begin
      rx_sh <= new_byte;
      if (byte_idx == 16'h0 && bit_cnt == 3'h0) begin
        frame_seq   <= ~frame_seq;
        frame_bytes <= 16'h0;
        data_cnt    <= 9'h0;
      end
      if (byte_done) begin
        frame_bytes <= next_idx;
        if (byte_idx == 16'h0) opcode <= new_byte;
        if (byte_idx != 16'h0 &&
            byte_idx < ((cur_op == op_sid_prog ||
                         cur_op == op_sid_read) ? hdr_sid : hdr_addr)) begin
          addr   <= {addr[15:0], new_byte};
          wr_ptr <= new_byte;
        end
        if (byte_idx == 16'h2 && cur_op == op_sid_read) begin
          sid_rd_addr <= {addr[2:0], new_byte}; // R21
        end
      end
      if (data_we) begin
        wr_ptr <= wr_ptr + 8'h1; // R11
        if (data_cnt != page_bytes) data_cnt <= data_cnt + 9'h1; // R10
      end
      if (tx_go) begin
        tx_sh <= quad_l2 ? {byte_out[3:0], 4'h0} : {byte_out[6:0], 1'h0};
        if (fetch && cur_op == op_sid_read) begin
          sid_rd_addr <= sid_rd_addr + 11'h1; // R21
        end
      end
    end
  end

  // ring write keeps the newest 256 bytes
  always_ff @(posedge link_sck) begin
    if (data_we) page_buf[wr_ptr] <= new_byte; // R10 R11
  end

  always_ff @(posedge link_sck or posedge sys_rst) begin
    if (sys_rst) begin
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
      wel_l1  <= 1'b0;
      wel_l2  <= 1'b0;
      quad_l1 <= 1'b0;
      quad_l2 <= 1'b0;
    end else begin
      busy_l1 <= busy;
      busy_l2 <= busy_l1;
      wel_l1  <= write_enable_latch;
      wel_l2  <= wel_l1;
      quad_l1 <= quad_core;
      quad_l2 <= quad_l1;
    end
  end

  // ----------------------------------------
  // pin filters
  // ----------------------------------------
  logic [2:0] pin_raw, pin_filt;

  assign pin_raw = {quad_io_config_bit, quad_io_protocol, ce_n};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_pin
      logic [2:0] s;
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          s           <= {3{pin_rst[i]}};
          pin_filt[i] <= pin_rst[i];
        end else begin
          s <= {s[1:0], pin_raw[i]};
          if (s[1] == s[2]) begin
            pin_filt[i] <= s[2];
          end
        end
      end
    end
  endgenerate

  assign quad_core = pin_filt[1];
  assign quad_cfg  = pin_filt[2];

  // ----------------------------------------
  // frame end and command decode
  // ----------------------------------------
  logic          ce_hi_d, seen_seq, frame_end, any_susp, do_susp;
  logic          do_resume, set_wel, e64;
  engine_state_t state;
  op_kind_t      run_kind, susp_kind, start_kind;
  logic [23:0]   timer, susp_left, run_addr, susp_addr, start_cyc;

  // link registers are quiet here: the clock stands still while ce is high
  assign frame_end = pin_filt[0] & ~ce_hi_d & (frame_seq != seen_seq); // R5
  assign any_susp  = erase_suspended_flag | program_suspended_flag;
  assign busy      = state != st_idle; // R26
  assign e64       = opcode == op_erase64;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ce_hi_d  <= 1'b1;
      seen_seq <= 1'b0;
    end else begin
      ce_hi_d <= pin_filt[0];
      if (pin_filt[0] & ~ce_hi_d) seen_seq <= frame_seq;
    end
  end

  always_comb begin
    start_kind = kind_none;
    start_cyc  = 24'h0;
    do_susp    = 1'b0;
    do_resume  = 1'b0;
    set_wel    = 1'b0;
    if (frame_end && state == st_idle) begin
      if (opcode == op_wr_en) begin
        set_wel = 1'b1; // R24
      end else if (opcode == op_resume) begin
        do_resume = any_susp; // R20
      end else if (write_enable_latch) begin // R4 R24
        if ((opcode == op_erase32 || e64) &&
            frame_bytes >= hdr_addr && // R27
            !prot_hit(protect_mask, addr, e64) && // R3
            !(program_suspended_flag &&
              in_block(susp_addr, addr, e64))) begin // R19
          start_kind = e64 ? kind_erase64 : kind_erase32; // R1 R2
          start_cyc  = 24'(erase_cycles);
        end
        if ((opcode == op_chip_a || opcode == op_chip_b) &&
            protect_mask == 16'h0 && !any_susp) begin // R6 R7 R15
          start_kind = kind_chip;
          start_cyc  = 24'(chip_cycles);
        end
        if ((opcode == op_prog ||
             (opcode == op_qprog && quad_cfg && !quad_core)) && // R12 R13
            data_cnt != 9'h0 && // R8 R27
            !prot_hit(protect_mask, addr, 1'b0) &&
            !(erase_suspended_flag &&
              in_block(addr, susp_addr,
                       susp_kind == kind_erase64))) begin // R18
          start_kind = kind_prog;
          start_cyc  = 24'(prog_cycles);
        end
        if (opcode == op_sid_prog && data_cnt != 9'h0 && !sid_locked &&
            addr[15:0] >= sid_user_lo && addr[15:0] <= sid_user_hi) begin
          start_kind = kind_sid_prog; // R22
          start_cyc  = 24'(sid_cycles);
        end
        if (opcode == op_sid_lock) begin
          start_kind = kind_sid_lock; // R23
          start_cyc  = 24'(sid_cycles);
        end
      end
    end
    if (frame_end && state == st_run && opcode == op_suspend &&
        !any_susp && (run_kind == kind_erase32 ||
                      run_kind == kind_erase64 ||
                      run_kind == kind_prog)) begin
      do_susp = 1'b1; // R14 R15
    end
  end

  // ----------------------------------------
  // self-timed engine
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state    <= st_idle;
      timer    <= 24'h0;
      run_kind <= kind_none;
      run_addr <= 24'h0;
      mem_done <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      unique case (state)
        st_idle: begin
          if (start_kind != kind_none) begin
            state    <= st_run; // R26
            timer    <= start_cyc;
            run_kind <= start_kind;
            run_addr <= addr;
          end else if (do_resume) begin
            state    <= st_run; // R20
            timer    <= susp_left;
            run_kind <= susp_kind;
            run_addr <= susp_addr;
          end
        end
        st_run: begin
          if (do_susp) begin
            state <= st_susp; // R17
            timer <= susp_cyc;
          end else if (timer == 24'h1) begin
            state    <= st_idle; // R26
            mem_done <= 1'b1;
          end else begin
            timer <= timer - 24'h1;
          end
        end
        st_susp: begin
          if (timer == 24'h1) begin
            state <= st_idle;
          end else begin
            timer <= timer - 24'h1;
          end
        end
      endcase
    end
  end

  // remaining time kept: resume continues, not restarts
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
      susp_kind              <= kind_none;
      susp_addr              <= 24'h0;
      susp_left              <= 24'h0;
    end else if (do_susp) begin
      erase_suspended_flag   <= run_kind != kind_prog; // R17
      program_suspended_flag <= run_kind == kind_prog; // R17
      susp_kind              <= run_kind;
      susp_addr              <= run_addr;
      susp_left              <= timer;
    end else if (do_resume) begin
      erase_suspended_flag   <= 1'b0; // R20
      program_suspended_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      write_enable_latch <= 1'b0;
    end else if (set_wel) begin
      write_enable_latch <= 1'b1; // R24
    end else if (start_kind != kind_none) begin
      write_enable_latch <= 1'b0;
    end
  end

  // volatile here: only a system reset clears the lock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sid_locked <= 1'b0;
    end else if (state == st_run && timer == 24'h1 &&
                 run_kind == kind_sid_lock) begin
      sid_locked <= 1'b1; // R23
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_req       <= '0;
      mem_req_valid <= 1'b0;
      page_rd_data  <= 8'h0;
    end else begin
      mem_req_valid <= state == st_idle && start_kind != kind_none;
      if (state == st_idle && start_kind != kind_none) begin
        mem_req.kind  <= start_kind;
        mem_req.addr  <= (start_kind == kind_sid_prog) ?
                         {8'h0, addr[15:0]} : addr;
        mem_req.count <= data_cnt;
      end
      page_rd_data <= page_buf[page_rd_idx];
    end
  end
endmodule // flash_erase_program_suspend_engine
`default_nettype wire

// ==== flash_engine_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------
// engine port checks
// ------------------
module flash_engine_monitor
  import flash_engine_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        link_sck,
  input wire logic [15:0] protect_mask,
  input wire sio_drive_t  sio,
  input wire mem_req_t    mem_req,
  input wire logic        mem_req_valid,
  input wire logic        mem_done,
  input wire logic        busy,
  input wire logic        write_enable_latch,
  input wire logic        erase_suspended_flag,
  input wire logic        program_suspended_flag
);
  sequence s_run;
    busy [*8];
  endsequence
  property p_start_busy;
    @(posedge ref_clk) disable iff (sys_rst) mem_req_valid |-> s_run;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy short");
  property p_start_wel;
    @(posedge ref_clk) disable iff (sys_rst)
    mem_req_valid |-> !write_enable_latch;
  endproperty
  a_start_wel: assert property (p_start_wel)
    else $error("wel kept");
  property p_done_pulse;
    @(posedge ref_clk) disable iff (sys_rst) mem_done |=> !mem_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done not a pulse");
  property p_chip_ok;
    @(posedge ref_clk) disable iff (sys_rst)
    mem_req_valid && mem_req.kind == kind_chip |-> protect_mask == 16'h0000
      && !erase_suspended_flag && !program_suspended_flag;
  endproperty
  a_chip_ok: assert property (p_chip_ok)
    else $error("bad chip erase");
  property p_blk_ok;
    @(posedge ref_clk) disable iff (sys_rst)
    mem_req_valid && mem_req.kind == kind_erase32
      |-> !protect_mask[mem_req.addr[18:15]];
  endproperty
  a_blk_ok: assert property (p_blk_ok)
    else $error("protected block erased");
  property p_one_susp;
    @(posedge ref_clk) disable iff (sys_rst)
    !(erase_suspended_flag && program_suspended_flag);
  endproperty
  a_one_susp: assert property (p_one_susp)
    else $error("two suspended operations");
  property p_esusp_src;
    @(posedge ref_clk) disable iff (sys_rst) $rose(erase_suspended_flag)
      |-> busy && mem_req.kind inside {kind_erase32, kind_erase64};
  endproperty
  a_esusp_src: assert property (p_esusp_src)
    else $error("bad erase suspend");
  property p_psusp_src;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(program_suspended_flag) |-> busy && mem_req.kind == kind_prog;
  endproperty
  a_psusp_src: assert property (p_psusp_src)
    else $error("bad program suspend");
  property p_resume;
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(erase_suspended_flag) || $fell(program_suspended_flag)
      |-> ##[0:1] busy;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no restart");
  property p_lanes;
    @(posedge link_sck) disable iff (sys_rst)
    sio.oe == 4'h0 || sio.oe == lane_spi || sio.oe == lane_quad;
  endproperty
  a_lanes: assert property (p_lanes)
    else $error("bad output lanes");
endmodule // flash_engine_monitor
`default_nettype wire

// ==== flash_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// -----------
// host driver
// -----------
module flash_host_model
  import flash_engine_pkg::*;
(
  output logic                             sck,
  output logic                             ce_n,
  output logic [3:0]                       sio_out,
  input  wire flash_engine_pkg::sio_drive_t sio
);
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    sio_out = 4'h0;
  end
  // clock stands still between frames
  task automatic open_frame;
    ce_n = 1'b0;
    #7;
  endtask
  // released lines flip so a stale value cannot pass for data
  task automatic close_frame;
    #3;
    ce_n = 1'b1;
    sio_out = ~sio_out;
  endtask
  // n clocks, msb first; q sends a nibble per clock
  task automatic shift(input logic [7:0] b, input int n, input bit q,
                       output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      sio_out = q ? (i[0] ? b[3:0] : b[7:4]) : {3'b000, b[7-i]};
      r = q ? {r[3:0], sio.dout} : {r[6:0], sio.dout[1]};
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
  endtask
endmodule // flash_host_model
`default_nettype wire

// ==== flash_erase_program_suspend_engine_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_erase_program_suspend_engine_tb;
  import flash_engine_pkg::*;
  // -----------------
  // signals and parts
  // -----------------
  typedef struct packed {
    logic [7:0]  op;
    logic [1:0]  na;
    logic [23:0] a;
    logic [8:0]  nd;
    logic [15:0] pm;
    op_kind_t    k;
  } row_t;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        quad_io_protocol = 1'b0;
  logic        quad_io_config_bit = 1'b0;
  logic [15:0] protect_mask = 16'h0000;
  logic [7:0]  page_rd_idx = 8'h00;
  logic [7:0]  page_rd_data, sid_rd_data, r;
  logic [10:0] sid_rd_addr;
  logic [3:0]  sio_in;
  logic        link_sck, ce_n, busy, write_enable_latch, sid_locked;
  logic        erase_suspended_flag, program_suspended_flag;
  logic        mem_req_valid, mem_done, seen;
  sio_drive_t  sio;
  mem_req_t    mem_req;
  int          miscompares = 0;
  int          check_count = 0;
  row_t rows [12] = '{
    '{op_erase32, 2'd3, 24'h0a8000, 9'd0, 16'h0000, kind_erase32},
    '{op_erase32, 2'd3, 24'h0a8000, 9'd0, 16'h0020, kind_none},
    '{op_erase64, 2'd3, 24'h0b0000, 9'd0, 16'h0020, kind_erase64},
    '{op_erase32, 2'd2, 24'h0a8000, 9'd0, 16'h0000, kind_none},
    '{op_chip_a, 2'd0, 24'h000000, 9'd0, 16'h0000, kind_chip},
    '{op_chip_b, 2'd0, 24'h000000, 9'd0, 16'h0000, kind_chip},
    '{op_chip_a, 2'd0, 24'h000000, 9'd0, 16'h8000, kind_none},
    '{op_prog, 2'd3, 24'h001200, 9'd1, 16'h0000, kind_prog},
    '{op_sid_prog, 2'd2, 24'h000010, 9'd1, 16'h0000, kind_sid_prog},
    '{op_sid_prog, 2'd2, 24'h00000f, 9'd1, 16'h0000, kind_none},
    '{op_sid_lock, 2'd0, 24'h000000, 9'd0, 16'h0000, kind_sid_lock},
    '{op_sid_prog, 2'd2, 24'h000020, 9'd1, 16'h0000, kind_none}};
  always #5 ref_clk = ~ref_clk;
  assign sid_rd_data = sid_rd_addr[7:0] ^ 8'h5a;
  flash_erase_program_suspend_engine #(.erase_cycles(400),
    .chip_cycles(400), .prog_cycles(200), .sid_cycles(40)) dut (
    .ref_clk, .sys_rst, .link_sck, .ce_n, .sio_in, .sio, .quad_io_protocol,
    .quad_io_config_bit, .protect_mask, .sid_rd_addr, .sid_rd_data,
    .mem_req, .mem_req_valid, .mem_done, .page_rd_idx, .page_rd_data,
    .busy, .write_enable_latch, .erase_suspended_flag,
    .program_suspended_flag, .sid_locked);
  flash_host_model host (.sck(link_sck), .ce_n, .sio_out(sio_in), .sio);
  // -----
  // tasks
  // -----
  task automatic check(input string what, input logic [35:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i == 3000) begin
        miscompares++;
        print_verdict();
      end
      @(negedge ref_clk);
    end
  endtask
  // frame, then 20 cycles watching for a start; w sends write enable first
  task automatic frame(input logic [7:0] op, input int na,
    input logic [23:0] a, input int nd, np, input bit q, w);
    int n;
    n = q ? 2 : 8;
    if (w) frame(op_wr_en, 0, 0, 0, 0, 0, 0);
    @(negedge ref_clk);
    host.open_frame();
    host.shift(op, 8, 1'b0, r);
    for (int i = na - 1; i >= 0; i--) host.shift(a[8*i +: 8], n, q, r);
    for (int i = 0; i < nd; i++) host.shift(8'(i) + {i[8], 6'h00}, n, q, r);
    if (np > 0) host.shift(8'hff, np, 1'b0, r);
    host.close_frame();
    seen = 1'b0;
    repeat (20) begin
      @(negedge ref_clk);
      if (mem_req_valid === 1'b1) seen = 1'b1;
    end
  endtask
  // read frame: opcode, nb byte slots; r keeps the last
  task automatic rdf(input logic [7:0] op, input int nb, input bit q);
    @(negedge ref_clk);
    host.open_frame();
    host.shift(op, q ? 2 : 8, q, r);
    repeat (nb) host.shift(8'h00, q ? 2 : 8, q, r);
    host.close_frame();
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic page(input logic [7:0] idx, exp);
    page_rd_idx = idx;
    repeat (2) @(negedge ref_clk);
    check("page", page_rd_data, exp);
  endtask
  // --------
  // sequence
  // --------
  initial begin
    row_t w;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("reset", {busy, write_enable_latch, erase_suspended_flag,
      program_suspended_flag, mem_req_valid, sid_locked, sio}, 0);
    foreach (rows[i]) begin
      w = rows[i];
      protect_mask = w.pm;
      frame(w.op, w.na, w.a, w.nd, 0, 0, 1);
      check("go", seen, w.k != kind_none);
      if (seen) check("kind", mem_req.kind, w.k);
      if (seen && w.nd != 0) check("count", mem_req.count, w.nd);
      wait_idle();
    end
    protect_mask = 16'h0000;
    frame(op_prog, 3, 24'h0034fe, 3, 4, 0, 1);
    check("count", mem_req.count, 3);
    wait_idle();
    page(8'hfe, 8'h00);
    page(8'hff, 8'h01);
    page(8'h00, 8'h02);
    frame(op_erase64, 3, 24'h020000, 0, 0, 0, 0);
    check("no wel", seen, 0);
    frame(op_prog, 3, 24'h003400, 258, 0, 0, 1);
    check("count", mem_req.count, 256);
    wait_idle();
    page(8'h00, 8'h40);
    page(8'h01, 8'h41);
    page(8'h02, 8'h02);
    frame(op_qprog, 3, 24'h005000, 2, 0, 1, 1);
    check("quad off", seen, 0);
    quad_io_config_bit = 1'b1;
    frame(op_qprog, 3, 24'h005000, 2, 0, 1, 1);
    check("quad", {seen, mem_req.count}, {1'b1, 9'd2});
    wait_idle();
    page(8'h01, 8'h01);
    frame(op_erase64, 3, 24'h010000, 0, 0, 0, 1);
    rdf(op_status, 1, 0);
    check("status", r, 8'h01);
    frame(op_suspend, 0, 0, 0, 0, 0, 0);
    check("flags", {erase_suspended_flag, program_suspended_flag, busy},
      3'b101);
    wait_idle();
    frame(op_chip_a, 0, 0, 0, 0, 0, 1);
    check("chip", seen, 0);
    frame(op_prog, 3, 24'h018000, 1, 0, 0, 1);
    check("prog", seen, 0);
    // suspends kept 500 us apart
    repeat (50000) @(negedge ref_clk);
    frame(op_suspend, 0, 0, 0, 0, 0, 0);
    check("resuspend", {erase_suspended_flag, busy}, 2'b10);
    frame(op_resume, 0, 0, 0, 0, 0, 0);
    check("resume", {erase_suspended_flag, busy}, 2'b01);
    wait_idle();
    rdf(op_sid_read, 5, 0);
    check("sid", r, 8'h5b);
    quad_io_protocol = 1'b1;
    repeat (6) @(negedge ref_clk);
    rdf(8'h00, 0, 1);
    rdf(op_wr_en, 0, 1);
    rdf(op_status, 2, 1);
    check("quad status", r, 8'h02);
    print_verdict();
  end
endmodule // flash_erase_program_suspend_engine_tb
bind flash_erase_program_suspend_engine flash_engine_monitor mon (
  .ref_clk, .sys_rst, .link_sck, .protect_mask, .sio, .mem_req,
  .mem_req_valid, .mem_done, .busy, .write_enable_latch,
  .erase_suspended_flag, .program_suspended_flag);
`default_nettype wire
